// [inc/flags_agen_pkg.sv]
`default_nettype none
package flags_agen_pkg;
	// Flag word layout
	localparam int FLAG_W = 16;
	localparam int CARRY_BIT = 0;
	localparam int PARITY_BIT = 2;
	localparam int AUX_BIT = 4;
	localparam int ZERO_BIT = 6;
	localparam int SIGN_BIT = 7;
	localparam int STEP_BIT = 8;
	localparam int IEN_BIT = 9;
	localparam int DIR_BIT = 10;
	localparam int OVF_BIT = 11;
	localparam logic [15:0] FLAG_RESET = 16'h0002;
	localparam logic [15:0] FIXED_ONE_MASK = 16'h0002;
	localparam logic [15:0] WRITABLE_MASK = 16'h0fd5;
	localparam logic [15:0] RESULT_MASK = 16'h08d5;
	// Operand widths
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;

	typedef enum logic [2:0]
	{
		ALU_ADD = 3'b000,
		ALU_SUB = 3'b001,
		ALU_AND = 3'b010,
		ALU_OR = 3'b011,
		ALU_XOR = 3'b100
	} alu_op_t;

	typedef enum logic [1:0]
	{
		REF_FETCH = 2'b00,
		REF_STACK = 2'b01,
		REF_DATA = 2'b10,
		REF_STR_DST = 2'b11
	} ref_kind_t;

	typedef enum logic [1:0]
	{
		SEG_EXTRA = 2'b00,
		SEG_CODE = 2'b01,
		SEG_STACK = 2'b10,
		SEG_DATA = 2'b11
	} seg_sel_t;

	typedef enum logic [2:0]
	{
		MODE_DIRECT = 3'b000,
		MODE_REG_IND = 3'b001,
		MODE_BASED = 3'b010,
		MODE_INDEXED = 3'b011,
		MODE_BASE_IDX = 3'b100,
		MODE_BASE_IDX_DISP = 3'b101
	} addr_mode_t;

	typedef enum logic [1:0]
	{
		IND_SRC = 2'b00,
		IND_DST = 2'b01,
		IND_BASE_GEN = 2'b10,
		IND_BASE_PTR = 2'b11
	} ind_reg_t;

	typedef enum logic
	{
		OPND_REG = 1'b0,
		OPND_IMM = 1'b1
	} opnd_kind_t;

	// Even count of ones in a byte
	function automatic logic parity_even(input logic [7:0] v);
		parity_even = ~(^v);
	endfunction
endpackage
`default_nettype wire

// [rtl/result_flag_calc.sv]
`default_nettype none
module result_flag_calc
	import flags_agen_pkg::*;
(
	// Operation
	input wire alu_op_t op_in,
	input wire logic word_in,
	input wire logic carry_in,
	// Operands
	input wire logic [15:0] a_in,
	input wire logic [15:0] b_in,
	// Result and flags at their word positions
	output logic [15:0] result_out,
	output logic [15:0] flags_out
);
	logic [16:0] wide;
	logic arith;
	logic is_sub;
	logic a_msb;
	logic b_msb;
	logic r_msb;

	// Carry into bit k is wide[k]^a[k]^b[k] for both add and subtract
	assign is_sub = (op_in == ALU_SUB);
	assign arith = (op_in == ALU_ADD) || is_sub;
	always_comb
	begin
		unique case (op_in)
			ALU_ADD: wide = {1'b0, a_in} + {1'b0, b_in} + {16'h0000, carry_in};
			ALU_SUB: wide = {1'b0, a_in} - {1'b0, b_in} - {16'h0000, carry_in};
			ALU_AND: wide = {1'b0, a_in & b_in};
			ALU_OR: wide = {1'b0, a_in | b_in};
			ALU_XOR: wide = {1'b0, a_in ^ b_in};
			default: wide = 17'h00000;
		endcase
	end

	assign result_out = word_in ? wide[15:0] : {8'h00, wide[7:0]};
	assign a_msb = word_in ? a_in[15] : a_in[7];
	assign b_msb = word_in ? b_in[15] : b_in[7];
	assign r_msb = word_in ? wide[15] : wide[7];

	// Flag bits placed at their positions, other bits zero
	always_comb
	begin
		flags_out = 16'h0000;
		flags_out[CARRY_BIT] = arith &&
			(word_in ? wide[16] : (wide[8] ^ a_in[8] ^ b_in[8]));
		flags_out[PARITY_BIT] = parity_even(wide[7:0]);
		flags_out[AUX_BIT] = arith && (wide[NIB_W] ^ a_in[NIB_W] ^ b_in[NIB_W]);
		flags_out[ZERO_BIT] = (result_out == 16'h0000);
		flags_out[SIGN_BIT] = r_msb;
		flags_out[OVF_BIT] = arith && ((a_msb ^ b_msb) == is_sub) && (r_msb != a_msb);
	end
endmodule
`default_nettype wire

// [rtl/offset_adder.sv]
`default_nettype none
module offset_adder
	import flags_agen_pkg::*;
(
	// Mode and element selects
	input wire addr_mode_t mode_in,
	input wire logic base_sel_in,
	input wire logic index_sel_in,
	input wire ind_reg_t ind_reg_in,
	input wire logic [15:0] disp_in,
	input wire logic disp_short_in,
	// Register contents
	input wire logic [15:0] base_general_in,
	input wire logic [15:0] base_pointer_in,
	input wire logic [15:0] source_index_in,
	input wire logic [15:0] dest_index_in,
	// Result
	output logic [15:0] offset_out,
	output logic bp_base_out
);
	logic [15:0] disp_ext;
	logic [15:0] base_val;
	logic [15:0] index_val;
	logic [15:0] ind_val;

	// Short displacement widened by its sign
	assign disp_ext = disp_short_in ? {{8{disp_in[7]}}, disp_in[7:0]} : disp_in;
	assign base_val = base_sel_in ? base_pointer_in : base_general_in;
	assign index_val = index_sel_in ? dest_index_in : source_index_in;

	// Exactly one register for indirect mode
	always_comb
	begin
		unique case (ind_reg_in)
			IND_SRC: ind_val = source_index_in;
			IND_DST: ind_val = dest_index_in;
			IND_BASE_GEN: ind_val = base_general_in;
			IND_BASE_PTR: ind_val = base_pointer_in;
		endcase
	end

	// Sums are 16 bits wide so the carry out of bit 15 falls away
	always_comb
	begin
		offset_out = 16'h0000;
		bp_base_out = 1'b0;
		unique case (mode_in)
			MODE_DIRECT: offset_out = disp_ext;
			MODE_REG_IND:
			begin
				offset_out = ind_val;
				bp_base_out = (ind_reg_in == IND_BASE_PTR);
			end
			MODE_BASED:
			begin
				offset_out = disp_ext + base_val;
				bp_base_out = base_sel_in;
			end
			MODE_INDEXED: offset_out = disp_ext + index_val;
			MODE_BASE_IDX:
			begin
				offset_out = base_val + index_val;
				bp_base_out = base_sel_in;
			end
			MODE_BASE_IDX_DISP:
			begin
				offset_out = base_val + index_val + disp_ext;
				bp_base_out = base_sel_in;
			end
			default: offset_out = 16'h0000;
		endcase
	end
endmodule
`default_nettype wire

// [rtl/flags_and_address_generation.sv]
// How it works
// - Carry flag from high-order carry or borrow
// - Parity flag set on even low-byte ones
// - Aux carry from low nibble carry/borrow
// - Zero flag set when result zero
// - Sign flag copies result top bit
// - Overflow flag on signed range overflow
// - Single step interrupts after instruction, clears flag
// - Interrupt enable gates maskable interrupt acceptance
// - Direction flag picks string index step sign
// - Segment spans up to 64K bytes
// - Address is 16-bit selector plus offset
// - Prefetch always uses code segment
// - Stack and base-pointer references use stack segment
// - Other data references use data segment
// - String destination uses extra segment
// - Override prefix replaces default segment for stack and data references only
// - Offset sum is 16 bits, carry dropped
// - Short displacement is sign extended
// - Direct mode offset is displacement alone
// - Register indirect uses one pointer register
// - Base from two bases, index from two indexes
// - Mode sums of displacement, base, index
// - Register or immediate operand selection
`default_nettype none
module flags_and_address_generation
	import flags_agen_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Result flag update
	input wire logic alu_valid_in,
	input wire alu_op_t alu_op_in,
	input wire logic alu_word_in,
	input wire logic alu_carry_in,
	input wire logic [15:0] alu_a_in,
	input wire logic [15:0] alu_b_in,
	input wire logic [15:0] flag_affect_mask_in,
	// Flag word load
	input wire logic flag_load_in,
	input wire logic [15:0] flag_load_value_in,
	input wire logic [15:0] flag_load_mask_in,
	// Instruction boundary and interrupts
	input wire logic instr_done_in,
	input wire logic intr_req_in,
	input wire logic [7:0] intr_vector_in,
	// String stepping
	input wire logic str_step_in,
	input wire logic str_word_in,
	// Segment registers
	input wire logic [15:0] code_segment_reg_in,
	input wire logic [15:0] stack_segment_reg_in,
	input wire logic [15:0] data_segment_reg_in,
	input wire logic [15:0] extra_segment_reg_in,
	// Base and index registers
	input wire logic [15:0] base_general_reg_in,
	input wire logic [15:0] base_pointer_reg_in,
	input wire logic [15:0] source_index_reg_in,
	input wire logic [15:0] dest_index_reg_in,
	// Address request
	input wire logic agen_req_in,
	input wire ref_kind_t ref_kind_in,
	input wire logic override_valid_in,
	input wire seg_sel_t override_seg_in,
	input wire addr_mode_t addr_mode_in,
	input wire logic base_sel_in,
	input wire logic index_sel_in,
	input wire ind_reg_t ind_reg_in,
	input wire logic [15:0] disp_in,
	input wire logic disp_short_in,
	input wire logic [15:0] fetch_offset_in,
	// Operand request
	input wire logic opnd_req_in,
	input wire opnd_kind_t opnd_kind_in,
	input wire logic opnd_word_in,
	input wire logic opnd_high_byte_in,
	input wire logic [15:0] opnd_reg_value_in,
	input wire logic [15:0] opnd_imm_in,
	// Flag word and interrupt outputs
	output logic [15:0] flag_word_out,
	output logic step_irq_out,
	output logic intr_take_out,
	output logic [7:0] intr_vector_out,
	// String outputs
	output logic str_valid_out,
	output logic [15:0] source_index_next_out,
	output logic [15:0] dest_index_next_out,
	// Address outputs
	output logic agen_valid_out,
	output seg_sel_t seg_used_out,
	output logic [15:0] seg_selector_out,
	output logic [15:0] offset_out,
	// Operand outputs
	output logic opnd_valid_out,
	output logic [15:0] opnd_value_out
);
	logic [15:0] flags_q;
	logic [15:0] flags_d;
	logic [15:0] calc_result;
	logic [15:0] calc_flags;
	logic [15:0] alu_mask;
	logic [15:0] load_mask;
	logic intr_meta_q;
	logic intr_sync_q;
	logic step_take;
	logic intr_take;
	logic [15:0] str_delta;
	logic [15:0] calc_offset;
	logic bp_base;
	seg_sel_t seg_default;
	seg_sel_t seg_pick;
	logic [15:0] seg_value;
	logic [15:0] offset_pick;
	logic override_ok;
	logic [15:0] reg_opnd;
	logic [15:0] opnd_pick;

	////////////////////////////////////////////////////////////////////////
	// Datapath leaves
	result_flag_calc u_flag_calc
	(
		.op_in(alu_op_in),
		.word_in(alu_word_in),
		.carry_in(alu_carry_in),
		.a_in(alu_a_in),
		.b_in(alu_b_in),
		.result_out(calc_result),
		.flags_out(calc_flags)
	);

	offset_adder u_offset_adder
	(
		.mode_in(addr_mode_in),
		.base_sel_in(base_sel_in),
		.index_sel_in(index_sel_in),
		.ind_reg_in(ind_reg_in),
		.disp_in(disp_in),
		.disp_short_in(disp_short_in),
		.base_general_in(base_general_reg_in),
		.base_pointer_in(base_pointer_reg_in),
		.source_index_in(source_index_reg_in),
		.dest_index_in(dest_index_reg_in),
		.offset_out(calc_offset),
		.bp_base_out(bp_base)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt pin synchroniser; only the second stage is read
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			intr_meta_q <= 1'b0;
			intr_sync_q <= 1'b0;
		end
		else
		begin
			intr_meta_q <= intr_req_in;
			intr_sync_q <= intr_meta_q;
		end
	end

	// Single step outranks the maskable request at a boundary
	assign step_take = instr_done_in && flags_q[STEP_BIT];
	assign intr_take = instr_done_in && !step_take && intr_sync_q && flags_q[IEN_BIT];

	////////////////////////////////////////////////////////////////////////
	// Flag word next value; only masked bits move, plus step and enable bits cleared when taken
	assign load_mask = flag_load_mask_in & WRITABLE_MASK;
	assign alu_mask = flag_affect_mask_in & RESULT_MASK;
	always_comb
	begin
		flags_d = flags_q;
		if (flag_load_in)
		begin
			flags_d = (flags_d & ~load_mask) | (flag_load_value_in & load_mask);
		end
		if (alu_valid_in)
		begin
			flags_d = (flags_d & ~alu_mask) | (calc_flags & alu_mask);
		end
		if (step_take)
		begin
			flags_d[STEP_BIT] = 1'b0;
		end
		if (intr_take)
		begin
			flags_d[IEN_BIT] = 1'b0;
		end
		flags_d = (flags_d & WRITABLE_MASK) | FIXED_ONE_MASK;
	end

	// Flag register and interrupt outputs
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			flags_q <= FLAG_RESET;
			step_irq_out <= 1'b0;
			intr_take_out <= 1'b0;
			intr_vector_out <= 8'h00;
		end
		else
		begin
			flags_q <= flags_d;
			step_irq_out <= step_take;
			intr_take_out <= intr_take;
			if (intr_take)
			begin
				intr_vector_out <= intr_vector_in;
			end
		end
	end
	assign flag_word_out = flags_q;

	////////////////////////////////////////////////////////////////////////
	// String index stepping; wraps inside the 64K segment
	assign str_delta = str_word_in ? STEP_WORD : STEP_BYTE;
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			str_valid_out <= 1'b0;
			source_index_next_out <= 16'h0000;
			dest_index_next_out <= 16'h0000;
		end
		else
		begin
			str_valid_out <= str_step_in;
			if (str_step_in && flags_q[DIR_BIT])
			begin
				source_index_next_out <= source_index_reg_in - str_delta;
				dest_index_next_out <= dest_index_reg_in - str_delta;
			end
			else if (str_step_in)
			begin
				source_index_next_out <= source_index_reg_in + str_delta;
				dest_index_next_out <= dest_index_reg_in + str_delta;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Implicit segment choice by reference kind
	always_comb
	begin
		unique case (ref_kind_in)
			REF_FETCH: seg_default = SEG_CODE;
			REF_STACK: seg_default = SEG_STACK;
			REF_DATA: seg_default = bp_base ? SEG_STACK : SEG_DATA;
			REF_STR_DST: seg_default = SEG_EXTRA;
		endcase
	end

	// Prefetch and string destination cannot be redirected
	assign override_ok = override_valid_in &&
		(ref_kind_in != REF_FETCH) && (ref_kind_in != REF_STR_DST);
	assign seg_pick = override_ok ? override_seg_in : seg_default;

	always_comb
	begin
		unique case (seg_pick)
			SEG_EXTRA: seg_value = extra_segment_reg_in;
			SEG_CODE: seg_value = code_segment_reg_in;
			SEG_STACK: seg_value = stack_segment_reg_in;
			SEG_DATA: seg_value = data_segment_reg_in;
		endcase
	end

	// Prefetch offset comes from the instruction pointer, not the modes
	assign offset_pick = (ref_kind_in == REF_FETCH) ? fetch_offset_in : calc_offset;

	// Selector and offset kept as two 16-bit parts
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			agen_valid_out <= 1'b0;
			seg_used_out <= SEG_CODE;
			seg_selector_out <= 16'h0000;
			offset_out <= 16'h0000;
		end
		else
		begin
			agen_valid_out <= agen_req_in;
			if (agen_req_in)
			begin
				seg_used_out <= seg_pick;
				seg_selector_out <= seg_value;
				offset_out <= offset_pick;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register or immediate operand
	assign reg_opnd = opnd_word_in ? opnd_reg_value_in :
		(opnd_high_byte_in ? {8'h00, opnd_reg_value_in[15:8]} :
		{8'h00, opnd_reg_value_in[7:0]});
	assign opnd_pick = (opnd_kind_in == OPND_IMM) ? opnd_imm_in : reg_opnd;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			opnd_valid_out <= 1'b0;
			opnd_value_out <= 16'h0000;
		end
		else
		begin
			opnd_valid_out <= opnd_req_in;
			if (opnd_req_in)
			begin
				opnd_value_out <= opnd_pick;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_step_boundary;
		instr_done_in && flag_word_out[STEP_BIT];
	endsequence
	sequence s_step_answer;
		step_irq_out && !flag_word_out[STEP_BIT];
	endsequence

	property p_carry_word;
		@(posedge clk_in) disable iff (rst_in)
		alu_valid_in && alu_word_in && alu_op_in == ALU_ADD && !flag_load_in &&
		flag_affect_mask_in[CARRY_BIT]
		|=> flag_word_out[CARRY_BIT] ==
		(({1'b0, $past(alu_a_in)} + {1'b0, $past(alu_b_in)} +
		{16'h0000, $past(alu_carry_in)}) > 17'h0ffff);
	endproperty
	a_carry_word: assert property (p_carry_word) else $error("carry flag wrong");

	property p_zero_sign;
		@(posedge clk_in) disable iff (rst_in)
		alu_valid_in && !flag_load_in && flag_affect_mask_in[ZERO_BIT] &&
		flag_affect_mask_in[SIGN_BIT]
		|=> flag_word_out[ZERO_BIT] == ($past(calc_result) == 16'h0000) &&
		flag_word_out[SIGN_BIT] == ($past(alu_word_in) ? $past(calc_result[15]) :
		$past(calc_result[7]));
	endproperty
	a_zero_sign: assert property (p_zero_sign) else $error("zero or sign flag wrong");

	property p_parity;
		@(posedge clk_in) disable iff (rst_in)
		alu_valid_in && !flag_load_in && flag_affect_mask_in[PARITY_BIT]
		|=> flag_word_out[PARITY_BIT] == parity_even($past(calc_result[7:0]));
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag wrong");

	property p_keep_unaffected;
		@(posedge clk_in) disable iff (rst_in)
		alu_valid_in && !flag_load_in && !instr_done_in
		|=> ((flag_word_out ^ $past(flag_word_out)) &
		~(RESULT_MASK & $past(flag_affect_mask_in))) == 16'h0000;
	endproperty
	a_keep_unaffected: assert property (p_keep_unaffected) else $error("flag moved");

	property p_single_step;
		@(posedge clk_in) disable iff (rst_in)
		s_step_boundary |=> s_step_answer ##1 !step_irq_out;
	endproperty
	a_single_step: assert property (p_single_step) else $error("single step missed");

	property p_intr_masked;
		@(posedge clk_in) disable iff (rst_in)
		!flag_word_out[IEN_BIT] |=> !intr_take_out;
	endproperty
	a_intr_masked: assert property (p_intr_masked) else $error("masked interrupt taken");

	property p_direction;
		@(posedge clk_in) disable iff (rst_in)
		str_step_in && flag_word_out[DIR_BIT] && !str_word_in
		|=> dest_index_next_out == $past(dest_index_reg_in) - STEP_BYTE;
	endproperty
	a_direction: assert property (p_direction) else $error("string step wrong");

	property p_prefetch_code;
		@(posedge clk_in) disable iff (rst_in)
		agen_req_in && ref_kind_in == REF_FETCH
		|=> agen_valid_out && seg_used_out == SEG_CODE &&
		seg_selector_out == $past(code_segment_reg_in);
	endproperty
	a_prefetch_code: assert property (p_prefetch_code) else $error("prefetch segment");

	property p_bp_stack;
		@(posedge clk_in) disable iff (rst_in)
		agen_req_in && ref_kind_in == REF_DATA && !override_valid_in &&
		addr_mode_in == MODE_BASED && base_sel_in
		|=> seg_used_out == SEG_STACK;
	endproperty
	a_bp_stack: assert property (p_bp_stack) else $error("base pointer segment");

	property p_override;
		@(posedge clk_in) disable iff (rst_in)
		agen_req_in && override_valid_in && ref_kind_in == REF_DATA
		|=> seg_used_out == $past(override_seg_in);
	endproperty
	a_override: assert property (p_override) else $error("override ignored");

	property p_offset_sum;
		@(posedge clk_in) disable iff (rst_in)
		agen_req_in && ref_kind_in != REF_FETCH && addr_mode_in == MODE_BASE_IDX &&
		!base_sel_in && !index_sel_in
		|=> offset_out == 16'($past(base_general_reg_in) + $past(source_index_reg_in));
	endproperty
	a_offset_sum: assert property (p_offset_sum) else $error("offset sum wrong");
endmodule
`default_nettype wire

// [sim/flags_and_address_generation_tb_top.sv]
`default_nettype none
`define CHK(g, e) \
	begin \
		n_compared++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
		end \
	end
module flags_and_address_generation_tb_top import flags_agen_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////
	// Stimulus, named as the ports
	logic clk_in = 0, rst_in = 1, alu_valid_in = 0, alu_word_in = 0, alu_carry_in = 0;
	alu_op_t alu_op_in = ALU_ADD;
	logic [15:0] alu_a_in = '0, alu_b_in = '0, flag_affect_mask_in = '0;
	logic flag_load_in = 0, instr_done_in = 0, intr_req_in = 0, str_step_in = 0;
	logic str_word_in = 0, agen_req_in = 0, override_valid_in = 0, base_sel_in = 0;
	logic index_sel_in = 0, disp_short_in = 0, opnd_req_in = 0, opnd_word_in = 0;
	logic opnd_high_byte_in = 0;
	logic [15:0] flag_load_value_in = '0, flag_load_mask_in = '0, disp_in = '0;
	logic [15:0] code_segment_reg_in = '0, stack_segment_reg_in = '0;
	logic [15:0] data_segment_reg_in = '0, extra_segment_reg_in = '0;
	logic [15:0] base_general_reg_in = '0, base_pointer_reg_in = '0;
	logic [15:0] source_index_reg_in = '0, dest_index_reg_in = '0, fetch_offset_in = '0;
	logic [15:0] opnd_reg_value_in = '0, opnd_imm_in = '0;
	logic [7:0] intr_vector_in = '0;
	ref_kind_t ref_kind_in = REF_FETCH;
	seg_sel_t override_seg_in = SEG_EXTRA;
	addr_mode_t addr_mode_in = MODE_DIRECT;
	ind_reg_t ind_reg_in = IND_SRC;
	opnd_kind_t opnd_kind_in = OPND_REG;
	logic [15:0] flag_word_out, source_index_next_out, dest_index_next_out;
	logic [15:0] seg_selector_out, offset_out, opnd_value_out;
	logic step_irq_out, intr_take_out, str_valid_out, agen_valid_out, opnd_valid_out;
	logic [7:0] intr_vector_out;
	seg_sel_t seg_used_out;
	int errors = 0, n_compared = 0;
	logic [31:0] seed = 32'd23;
	logic [15:0] fm = 16'h0002;
	logic [15:0] r, d, bs, ix, o, sv, e;
	seg_sel_t s;
	logic bpb;

	flags_and_address_generation dut_u (.clk_in, .rst_in, .alu_valid_in, .alu_op_in,
		.alu_word_in, .alu_carry_in, .alu_a_in, .alu_b_in, .flag_affect_mask_in, .flag_load_in,
		.flag_load_value_in, .flag_load_mask_in, .instr_done_in, .intr_req_in, .intr_vector_in,
		.str_step_in, .str_word_in, .code_segment_reg_in, .stack_segment_reg_in,
		.data_segment_reg_in, .extra_segment_reg_in, .base_general_reg_in,
		.base_pointer_reg_in, .source_index_reg_in, .dest_index_reg_in, .agen_req_in,
		.ref_kind_in, .override_valid_in, .override_seg_in, .addr_mode_in, .base_sel_in,
		.index_sel_in, .ind_reg_in, .disp_in, .disp_short_in, .fetch_offset_in, .opnd_req_in,
		.opnd_kind_in, .opnd_word_in, .opnd_high_byte_in, .opnd_reg_value_in, .opnd_imm_in,
		.flag_word_out, .step_irq_out, .intr_take_out, .intr_vector_out, .str_valid_out,
		.source_index_next_out, .dest_index_next_out, .agen_valid_out, .seg_used_out,
		.seg_selector_out, .offset_out, .opnd_valid_out, .opnd_value_out);

	// Free-running 100 MHz clock
	always #5 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////
	// Xorshift source, fixed start
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	// Reference flags from operands and carry in, written bit by bit
	function automatic logic [15:0] ref_flags(alu_op_t op, logic w, logic ci,
		logic [15:0] a, logic [15:0] b);
		logic [16:0] x;
		logic [4:0] n;
		logic c, v, sg, sa, sb;
		if (!w)
		begin
			a &= 16'h00ff;
			b &= 16'h00ff;
		end
		n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
		x = {1'b0, a} + {1'b0, b} + ci;
		if (op == ALU_SUB) n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci;
		if (op == ALU_SUB) x = {1'b0, a} - {1'b0, b} - ci;
		if (op == ALU_AND) x = {1'b0, a & b};
		if (op == ALU_OR) x = {1'b0, a | b};
		if (op == ALU_XOR) x = {1'b0, a ^ b};
		sg = w ? x[15] : x[7];
		sa = w ? a[15] : a[7];
		sb = w ? b[15] : b[7];
		c = w ? x[16] : x[8];
		v = (op == ALU_SUB) ? (sa != sb) && (sg != sa) : (sa == sb) && (sg != sa);
		if (op > ALU_SUB)
		begin
			c = 0;
			v = 0;
			n = '0;
		end
		return {4'h0, v, 3'h0, sg, w ? x[15:0] == 0 : x[7:0] == 0, 1'b0, n[4], 1'b0,
			~^x[7:0], 1'b1, c};
	endfunction

	task automatic tick();
		@(posedge clk_in);
	endtask

	// One flag-word load, model follows
	task automatic load(input logic [15:0] v, input logic [15:0] m);
		tick();
		flag_load_in <= 1;
		flag_load_value_in <= v;
		flag_load_mask_in <= m;
		tick();
		flag_load_in <= 0;
		#1;
		fm = (fm & ~(m & WRITABLE_MASK)) | (v & m & WRITABLE_MASK) | FIXED_ONE_MASK;
		`CHK(flag_word_out, fm);
	endtask

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard, far beyond the under one thousand cycles used
	initial
	begin
		#300000;
		errors++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (5) tick();
		rst_in <= 0;
		#1;
		`CHK(flag_word_out, 16'h0002);
		// Result flags, random ops and partial masks so untouched bits must hold
		for (int i = 0; i < 200; i++)
		begin
			tick();
			r = rnd();
			alu_op_in <= alu_op_t'(r[2:0] % 3'd5);
			alu_word_in <= r[3];
			alu_carry_in <= r[6];
			alu_a_in <= (i < 5) ? 16'hffff : rnd();
			alu_b_in <= (i < 5) ? {15'h0, r[4]} : rnd();
			flag_affect_mask_in <= r[5] ? 16'hffff : rnd();
			alu_valid_in <= 1;
			tick();
			alu_valid_in <= 0;
			#1;
			e = flag_affect_mask_in & RESULT_MASK;
			fm = (fm & ~e) | (ref_flags(alu_op_in, alu_word_in, alu_carry_in, alu_a_in, alu_b_in) & e);
			`CHK(flag_word_out, fm);
		end
		$display("test result_flags done");
		// String stepping under both directions
		for (int i = 0; i < 16; i++)
		begin
			load({5'h0, i[0], 10'h0}, 16'h0400);
			tick();
			source_index_reg_in <= (i < 4) ? 16'hffff : rnd();
			dest_index_reg_in <= (i < 4) ? 16'h0000 : rnd();
			str_word_in <= i[1];
			str_step_in <= 1;
			tick();
			str_step_in <= 0;
			#1;
			e = str_word_in ? STEP_WORD : STEP_BYTE;
			d = fm[10] ? 16'h0000 - e : e;
			`CHK(str_valid_out, 1'b1);
			`CHK(source_index_next_out, 16'(source_index_reg_in + d));
			`CHK(dest_index_next_out, 16'(dest_index_reg_in + d));
		end
		$display("test string_step done");
		// Segment choice and offset sums over every kind and mode
		for (int i = 0; i < 120; i++)
		begin
			tick();
			r = rnd();
			code_segment_reg_in <= rnd();
			stack_segment_reg_in <= rnd();
			data_segment_reg_in <= rnd();
			extra_segment_reg_in <= rnd();
			base_general_reg_in <= rnd();
			base_pointer_reg_in <= rnd();
			source_index_reg_in <= rnd();
			dest_index_reg_in <= rnd();
			disp_in <= rnd();
			fetch_offset_in <= rnd();
			ref_kind_in <= ref_kind_t'(r[1:0]);
			override_valid_in <= r[2];
			override_seg_in <= seg_sel_t'(r[4:3]);
			addr_mode_in <= addr_mode_t'(r[7:5] % 3'd6);
			base_sel_in <= r[8];
			index_sel_in <= r[9];
			ind_reg_in <= ind_reg_t'(r[11:10]);
			disp_short_in <= r[12];
			agen_req_in <= 1;
			tick();
			agen_req_in <= 0;
			#1;
			d = disp_short_in ? {{8{disp_in[7]}}, disp_in[7:0]} : disp_in;
			bs = base_sel_in ? base_pointer_reg_in : base_general_reg_in;
			ix = index_sel_in ? dest_index_reg_in : source_index_reg_in;
			case (ind_reg_in)
				IND_SRC: o = source_index_reg_in;
				IND_DST: o = dest_index_reg_in;
				IND_BASE_GEN: o = base_general_reg_in;
				default: o = base_pointer_reg_in;
			endcase
			bpb = (addr_mode_in == MODE_REG_IND) ? ind_reg_in == IND_BASE_PTR : base_sel_in &&
				addr_mode_in inside {MODE_BASED, MODE_BASE_IDX, MODE_BASE_IDX_DISP};
			if (addr_mode_in == MODE_DIRECT) o = d;
			if (addr_mode_in == MODE_BASED) o = d + bs;
			if (addr_mode_in == MODE_INDEXED) o = d + ix;
			if (addr_mode_in == MODE_BASE_IDX) o = bs + ix;
			if (addr_mode_in == MODE_BASE_IDX_DISP) o = d + bs + ix;
			s = (ref_kind_in == REF_STACK || (ref_kind_in == REF_DATA && bpb)) ? SEG_STACK :
				(ref_kind_in == REF_DATA) ? SEG_DATA : SEG_EXTRA;
			if (ref_kind_in == REF_FETCH)
			begin
				s = SEG_CODE;
				o = fetch_offset_in;
			end
			if (override_valid_in && ref_kind_in inside {REF_STACK, REF_DATA}) s = override_seg_in;
			sv = (s == SEG_CODE) ? code_segment_reg_in : (s == SEG_STACK) ? stack_segment_reg_in :
				(s == SEG_DATA) ? data_segment_reg_in : extra_segment_reg_in;
			`CHK(agen_valid_out, 1'b1);
			`CHK(seg_used_out, s);
			`CHK(seg_selector_out, sv);
			`CHK(offset_out, o);
		end
		$display("test address_gen done");
		// Register and immediate operands, byte halves zero-extended
		for (int i = 0; i < 24; i++)
		begin
			tick();
			r = rnd();
			opnd_kind_in <= opnd_kind_t'(r[0]);
			opnd_word_in <= r[1];
			opnd_high_byte_in <= r[2];
			opnd_reg_value_in <= rnd();
			opnd_imm_in <= rnd();
			opnd_req_in <= 1;
			tick();
			opnd_req_in <= 0;
			#1;
			e = (opnd_kind_in == OPND_IMM) ? opnd_imm_in : opnd_high_byte_in && !opnd_word_in ?
				{8'h0, opnd_reg_value_in[15:8]} : opnd_reg_value_in;
			`CHK(opnd_valid_out, 1'b1);
			`CHK(opnd_value_out, opnd_word_in || opnd_kind_in == OPND_IMM ? e : {8'h0, e[7:0]});
		end
		$display("test operand done");
		// Single step: pulse after the boundary, flag cleared
		load(16'h0100, 16'h0300);
		tick();
		instr_done_in <= 1;
		tick();
		instr_done_in <= 0;
		#1;
		fm[8] = 0;
		`CHK(step_irq_out, 1'b1);
		`CHK(flag_word_out, fm);
		// Maskable request: taken when enabled, ignored when not
		load(16'h0200, 16'h0300);
		tick();
		intr_req_in <= 1;
		intr_vector_in <= 8'h5a;
		repeat (4) tick();
		instr_done_in <= 1;
		tick();
		instr_done_in <= 0;
		#1;
		fm[9] = 0;
		`CHK(intr_take_out, 1'b1);
		`CHK(intr_vector_out, 8'h5a);
		`CHK(flag_word_out, fm);
		tick();
		instr_done_in <= 1;
		tick();
		instr_done_in <= 0;
		intr_req_in <= 0;
		#1;
		`CHK(intr_take_out, 1'b0);
		$display("test interrupts done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
